// file: logic/bis_map.svh
// bis_map.svh: addresses, field positions, reset values and step numbers
// assumes: included by bare name into the sequencer file
`ifndef BIS_MAP_SVH
`define BIS_MAP_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define BIS_CTRL_ADDR 32'h3018_0000
`define BIS_STAT_ADDR 32'h3018_0004
`define BIS_BSTAT_ADDR 32'h3018_0008
`define BIS_CAUSE_ADDR 32'h3018_000c
`define BIS_PARTNUM_ADDR 32'h3018_0024
`define BIS_REVID_ADDR 32'h3018_0028
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define BIS_CTRL_LDR_DIS_BIT 0
`define BIS_CAUSE_POR_BIT 0
`define BIS_CAUSE_XRS_BIT 1
`define BIS_CTRL_LDR_DIS_RST 1'b0
`define BIS_POR_TYPE_RST 1'b1
// ---------------------------------------------------------------
// step numbers
// ---------------------------------------------------------------
`define BIS_STEP_FIRST 5'h01
`define BIS_STEP_RAMINIT 5'h05
`define BIS_STEP_XTAL 5'h0b
`define BIS_STEP_LOCK 5'h0f
`define BIS_STEP_RAMWAIT 5'h10
`define BIS_STEP_CAUSE 5'h11
`define BIS_STEP_BOOTSEL 5'h13
`define BIS_STEP_LAST 5'h16
`define BIS_STEP_COUNT 22
`endif

// file: logic/bis_pkg.sv
// bis_pkg.sv: types of the boot init sequencer
// assumes: compiled before the sequencer module
package bis_pkg;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_DONE} bis_state_t;
  typedef struct packed {
    bis_state_t st;
    logic [4:0] step;
    logic por_type;
    logic [21:0] bstat;
    logic cause_por;
    logic cause_xrs;
    logic [2:0] bmode;
    logic lock;
    logic xtal;
    logic loader_dis;
    logic por_s1;
    logic por_s2;
    logic xrs_s1;
    logic xrs_s2;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic dsel;
    logic dwr;
    logic [31:0] daddr;
    logic [31:0] rdata;
  } bis_regs_t;
endpackage

// file: logic/bis_boot_seq.sv
// bis_boot_seq.sv: reset-triggered boot init sequencer with AHB-Lite registers
// assumes: one 100 MHz clock; reset pins and boot pins asynchronous;
// step actions acknowledged by step_done, step 16 by ram_init_done, on the same clock
//
// Functional notes
// - run sequence after every reset, branches by type
// - step 1 flash waits, step 2 watchdog
// - steps 3-4 copy password, then unique id
// - step 5 RAM init only on power-on
// - step 6 critical trims and config regs
// - step 7 error groups, step 8 interconnect
// - step 9 copy protection policy revision
// - step 10 configure error status pin
// - step 11 crystal on only if enabled
// - step 12 copy capability configs
// - step 13 non-critical converter trims
// - step 14 security self-test then configure
// - step 15 lock configuration registers
// - step 16 wait RAM init on power-on
// - step 17 clear causes by reset type
// - step 18 pull-ups on unbonded pads
// - step 19 sample boot pins, run loader
// - steps 20-21 open then lock context RAM
// - step 22 set protection regions
// - keep boot status word of taken steps
// - peripheral loaders can be disabled
// - read-only part number register at 0x30180024
`include "bis_map.svh"
`timescale 1ns/1ps
`default_nettype none

module bis_boot_seq #(
  parameter logic [31:0] PART_NUMBER = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] REVISION = 32'h0000_0001 // arbitrary value
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic power_on_reset_in_n,
  input wire logic external_reset_in_n,
  input wire logic [2:0] boot_pins,
  input wire logic otp_xtal_en,
  input wire logic step_done,
  input wire logic ram_init_done,
  output logic step_req,
  output logic [4:0] step_num,
  output logic seq_busy,
  output logic seq_done,
  output logic por_type,
  output logic [2:0] boot_mode,
  output logic loader_enable,
  output logic config_lock,
  output logic xtal_on,
  output logic [21:0] boot_status,
  output logic cause_por,
  output logic cause_xrs,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  bis_pkg::bis_regs_t r;
  bis_pkg::bis_regs_t next_r;

  logic skip;
  logic done_ok;
  logic addr_ok;
  logic wr_ctrl;
  logic [31:0] rd_val;
  logic [`BIS_STEP_COUNT-1:0] step_grant;

  // conditional steps: power-on only, or crystal enable
  always_comb begin
    skip = 1'b0;
    if ((r.step == `BIS_STEP_RAMINIT || r.step == `BIS_STEP_RAMWAIT) && !r.por_type) begin
      skip = 1'b1;
    end
    if (r.step == `BIS_STEP_XTAL && !otp_xtal_en) begin
      skip = 1'b1;
    end
  end

  // step 16 completes on RAM init done, all others on their own ack
  assign done_ok = (r.step == `BIS_STEP_RAMWAIT) ? ram_init_done : step_done;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_ctrl = r.dsel && r.dwr && (r.daddr == `BIS_CTRL_ADDR) && !r.lock;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr)
      `BIS_CTRL_ADDR: rd_val[`BIS_CTRL_LDR_DIS_BIT] = r.loader_dis;
      `BIS_STAT_ADDR: rd_val = {16'h0000, r.bmode, r.xtal, r.lock, r.por_type,
                                r.st == bis_pkg::S_DONE, r.st != bis_pkg::S_DONE, 3'h0, r.step};
      `BIS_BSTAT_ADDR: rd_val = {10'h000, r.bstat};
      `BIS_CAUSE_ADDR: begin
        rd_val[`BIS_CAUSE_POR_BIT] = r.cause_por;
        rd_val[`BIS_CAUSE_XRS_BIT] = r.cause_xrs;
      end
      `BIS_PARTNUM_ADDR: rd_val = PART_NUMBER;
      `BIS_REVID_ADDR: rd_val = REVISION;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.por_s1 = power_on_reset_in_n;
    next_r.por_s2 = r.por_s1;
    next_r.xrs_s1 = external_reset_in_n;
    next_r.xrs_s2 = r.xrs_s1;
    next_r.pin_s1 = boot_pins;
    next_r.pin_s2 = r.pin_s1;

    // bus slave: capture address phase, act in data phase
    next_r.dsel = addr_ok;
    next_r.dwr = addr_ok && hwrite;
    next_r.daddr = haddr;
    if (addr_ok && !hwrite) begin
      next_r.rdata = rd_val;
    end
    if (wr_ctrl) begin
      next_r.loader_dis = hwdata[`BIS_CTRL_LDR_DIS_BIT];
    end

    case (r.st)
      bis_pkg::S_IDLE: begin
        if (r.por_s2 && r.xrs_s2) begin
          next_r.st = bis_pkg::S_ISSUE;
          next_r.step = `BIS_STEP_FIRST;
        end
      end
      bis_pkg::S_ISSUE: begin
        if (r.step == `BIS_STEP_BOOTSEL) begin
          next_r.bmode = r.pin_s2;
        end
        if (skip) begin
          next_r.step = r.step + 5'h01;
        end else begin
          next_r.st = bis_pkg::S_WAIT;
        end
      end
      bis_pkg::S_WAIT: begin
        if (done_ok) begin
          next_r.bstat[r.step - 5'h01] = 1'b1;
          if (r.step == `BIS_STEP_XTAL) begin
            next_r.xtal = 1'b1;
          end
          if (r.step == `BIS_STEP_LOCK) begin
            next_r.lock = 1'b1;
          end
          if (r.step == `BIS_STEP_CAUSE) begin
            next_r.cause_xrs = 1'b0;
            if (r.por_type) begin
              next_r.cause_por = 1'b0;
            end
          end
          if (r.step == `BIS_STEP_LAST) begin
            next_r.st = bis_pkg::S_DONE;
          end else begin
            next_r.st = bis_pkg::S_ISSUE;
            next_r.step = r.step + 5'h01;
          end
        end
      end
      bis_pkg::S_DONE: begin
        next_r.st = bis_pkg::S_DONE;
      end
      default: next_r.st = bis_pkg::S_IDLE;
    endcase

    // a reset pin restarts the sequence; cause set wins over clear
    if (!r.xrs_s2) begin
      next_r.cause_xrs = 1'b1;
      next_r.por_type = 1'b0;
    end
    if (!r.por_s2) begin
      next_r.cause_por = 1'b1;
      next_r.por_type = 1'b1;
    end
    if (!r.por_s2 || !r.xrs_s2) begin
      next_r.st = bis_pkg::S_IDLE;
      next_r.step = 5'h00;
      next_r.bstat = 22'h00_0000;
      next_r.lock = 1'b0;
      next_r.xtal = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= bis_pkg::S_IDLE;
      r.por_type <= `BIS_POR_TYPE_RST;
      r.cause_por <= 1'b1;
      r.loader_dis <= `BIS_CTRL_LDR_DIS_RST;
      // reset pins idle high: a low start would log a false cause
      r.por_s1 <= 1'b1;
      r.por_s2 <= 1'b1;
      r.xrs_s1 <= 1'b1;
      r.xrs_s2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign step_req = (r.st == bis_pkg::S_ISSUE) && !skip;
  assign step_num = r.step;
  assign seq_busy = (r.st != bis_pkg::S_DONE);
  assign seq_done = (r.st == bis_pkg::S_DONE);
  assign por_type = r.por_type;
  assign boot_mode = r.bmode;
  assign loader_enable = !r.loader_dis;
  assign config_lock = r.lock;
  assign xtal_on = r.xtal;
  assign boot_status = r.bstat;
  assign cause_por = r.cause_por;
  assign cause_xrs = r.cause_xrs;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;

  // ---------------------------------------------------------------
  // step strobes: one per step, high while that step is issued
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `BIS_STEP_COUNT; g++) begin : g_grant
    assign step_grant[g] = step_req && (step_num == 5'(g + 1));
  end : g_grant

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_step_ends;
    r.st == bis_pkg::S_WAIT && done_ok && r.por_s2 && r.xrs_s2;
  endsequence

  sequence s_next_issued;
    r.st == bis_pkg::S_ISSUE;
  endsequence

  chk_step_order: assert property (s_step_ends and (r.step != `BIS_STEP_LAST) |=>
    s_next_issued and step_num == $past(step_num) + 5'h01)
    else $error("step did not advance by one");
  chk_raminit_por: assert property (step_req && step_num == `BIS_STEP_RAMINIT |-> por_type)
    else $error("ram init requested without power-on");
  chk_ram_wait: assert property (r.st == bis_pkg::S_WAIT && step_num == `BIS_STEP_RAMWAIT
    && !ram_init_done && r.por_s2 && r.xrs_s2 |=> r.st == bis_pkg::S_WAIT && step_num == `BIS_STEP_RAMWAIT)
    else $error("left ram wait early");
  chk_cause_clear: assert property (s_step_ends and step_num == `BIS_STEP_CAUSE && !por_type
    |=> !cause_xrs && cause_por == $past(cause_por))
    else $error("wrong reset causes cleared");
  chk_xtal_cause: assert property ($rose(xtal_on) |-> $past(step_num) == `BIS_STEP_XTAL
    && $past(otp_xtal_en))
    else $error("crystal enabled outside its step");
  chk_lock_step: assert property ($rose(config_lock) |-> $past(step_num) == `BIS_STEP_LOCK)
    else $error("lock set outside its step");
  chk_locked_wr: assert property (r.dsel && r.dwr && config_lock |=> $stable(loader_enable))
    else $error("control changed while locked");
  chk_boot_sample: assert property (r.st == bis_pkg::S_ISSUE && step_num == `BIS_STEP_BOOTSEL
    && r.por_s2 && r.xrs_s2 |=> boot_mode == $past(r.pin_s2))
    else $error("boot pins not sampled");
  chk_status_bit: assert property (s_step_ends |=> boot_status[$past(step_num) - 5'h01])
    else $error("boot status bit not recorded");
  chk_part_read: assert property (addr_ok && !hwrite && haddr == `BIS_PARTNUM_ADDR
    |=> hrdata == PART_NUMBER)
    else $error("part number read wrong");

  // ---------------------------------------------------------------
  // step checks: steps 1-2, 4, 6-10, 12-15, 18 and 20-22 issued only after their predecessors; step 11 only if enabled; step 16 only after step 5
  // ---------------------------------------------------------------
  chk_flash_first: assert property (step_grant[0]
    |-> boot_status == 22'h00_0000)
    else $error("flash waits not first step");
  chk_wdog_second: assert property (step_grant[1]
    |-> boot_status == 22'h00_0001)
    else $error("watchdog not second step");
  chk_password_id: assert property (step_grant[3]
    |-> boot_status[2:0] == 3'h7)
    else $error("unique id before password");
  chk_trim_order: assert property (step_grant[5]
    |-> boot_status[3:0] == 4'hf && boot_status[4] == por_type)
    else $error("critical trims out of order");
  chk_error_group: assert property (step_grant[6]
    |-> boot_status[5])
    else $error("error groups before trims");
  chk_interconnect: assert property (step_grant[7]
    |-> boot_status[6])
    else $error("interconnect before error groups");
  chk_policy_rev: assert property (step_grant[8]
    |-> boot_status[7])
    else $error("policy revision out of order");
  chk_error_pin: assert property (step_grant[9]
    |-> boot_status[8])
    else $error("error pin set out of order");
  chk_xtal_skip: assert property (step_grant[10]
    |-> otp_xtal_en)
    else $error("crystal step issued while disabled");
  chk_capability: assert property (step_grant[11]
    |-> boot_status[9] && boot_status[10] == xtal_on)
    else $error("capability copy out of order");
  chk_conv_trims: assert property (step_grant[12]
    |-> boot_status[11] && boot_status[5])
    else $error("converter trims before critical trims");
  chk_sec_selftest: assert property (step_grant[13]
    |-> boot_status[12])
    else $error("security setup out of order");
  chk_lock_after: assert property (step_grant[14]
    |-> boot_status[13] && !config_lock)
    else $error("lock step out of order");
  chk_ram_wait_por: assert property (step_grant[15]
    |-> por_type && boot_status[4])
    else $error("ram wait without power-on init");
  chk_cause_done: assert property (step_grant[17]
    |-> !cause_xrs && !(por_type && cause_por))
    else $error("causes not cleared before pull-ups");
  chk_pad_pullups: assert property (step_grant[17]
    |-> boot_status[16])
    else $error("pull-ups before cause clear");
  chk_ram_open: assert property (step_grant[19]
    |-> boot_status[18])
    else $error("context ram opened before boot select");
  chk_ram_commit: assert property (step_grant[20]
    |-> boot_status[19])
    else $error("context ram committed before open");
  chk_prot_regions: assert property (step_grant[21]
    |-> boot_status[20])
    else $error("protection regions out of order");

endmodule // bis_boot_seq

`default_nettype wire

// file: verif/tb_boot_init_sequencer.sv
// tb_boot_init_sequencer.sv: self-checking bench for the boot init sequencer
// assumes: bis_map.svh, bis_pkg and bis_boot_seq compiled first, default parameters
`include "bis_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_boot_init_sequencer;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic por_n = 1'b1;
  logic xrs_n = 1'b1;
  logic xe = 1'b1;
  logic sdone = 1'b0;
  logic rdone = 1'b0;
  logic [2:0] pins = 3'h3;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic step_req, seq_busy, seq_done, por_type, loader_enable, config_lock, xtal_on;
  logic cause_por, cause_xrs, hreadyout, hresp;
  logic [4:0] step_num;
  logic [2:0] boot_mode;
  logic [21:0] boot_status;
  logic [31:0] hrdata;
  int n_mismatch = 0;
  int checks_done = 0;

  always #5 clock = ~clock;

  bis_boot_seq u_dut (.clock(clock), .arst_n(arst_n), .power_on_reset_in_n(por_n),
    .external_reset_in_n(xrs_n), .boot_pins(pins), .otp_xtal_en(xe), .step_done(sdone),
    .ram_init_done(rdone), .step_req(step_req), .step_num(step_num), .seq_busy(seq_busy),
    .seq_done(seq_done), .por_type(por_type), .boot_mode(boot_mode),
    .loader_enable(loader_enable), .config_lock(config_lock), .xtal_on(xtal_on),
    .boot_status(boot_status), .cause_por(cause_por), .cause_xrs(cause_xrs), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    n_mismatch++;
    $display("BAD %0t %s timed out", $time, msg);
    print_verdict;
  endtask

  // single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    k = 0;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) hang("bus");
    // written state is visible only one edge after the data phase
    if (wr) @(posedge clock);
    chk(32'(hresp), 32'h0, "response");
  endtask

  // answers every step request, slow on some, and checks order and results
  task automatic run_seq(input logic por, input logic xen);
    int n;
    logic [4:0] e;
    logic [21:0] mask;
    e = `BIS_STEP_FIRST;
    mask = 22'h0;
    for (n = 0; n < 400 && e <= `BIS_STEP_LAST; n++) begin
      @(posedge clock);
      if (step_req === 1'b1) begin
        chk(32'(step_num), 32'(e), "step number");
        mask[e - 5'h01] = 1'b1;
        repeat (e % 3) @(posedge clock);
        if (e == `BIS_STEP_RAMWAIT) rdone <= 1'b1;
        else sdone <= 1'b1;
        @(posedge clock);
        rdone <= 1'b0;
        sdone <= 1'b0;
        e++;
        while ((!por && (e == `BIS_STEP_RAMINIT || e == `BIS_STEP_RAMWAIT)) || (!xen && e == `BIS_STEP_XTAL)) e++;
      end
    end
    if (e <= `BIS_STEP_LAST) hang("sequence");
    repeat (2) @(posedge clock);
    chk(32'({seq_done, seq_busy}), 32'h2, "done flags");
    chk(32'(boot_status), 32'(mask), "boot status");
    chk(32'(config_lock), 32'h1, "lock");
    chk(32'(xtal_on), 32'(xen), "crystal");
    chk(32'({cause_xrs, cause_por}), 32'h0, "causes");
    chk(32'(boot_mode), 32'(pins), "boot mode");
    chk(32'(por_type), 32'(por), "reset type");
  endtask

  // pulls one reset pin, checks the recorded cause, then releases it
  task automatic pin_reset(input logic por);
    if (por) por_n <= 1'b0;
    else xrs_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk(32'({cause_xrs, cause_por}), por ? 32'h1 : 32'h2, "cause set");
    chk(32'({por_type, config_lock, xtal_on}), por ? 32'h4 : 32'h0, "restart");
    por_n <= 1'b1;
    xrs_n <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    fork
      run_seq(1'b1, 1'b1);
      begin
        bus(1'b1, `BIS_CTRL_ADDR, 32'h1);
        chk(32'(loader_enable), 32'h0, "loader off");
        bus(1'b0, `BIS_CAUSE_ADDR, 32'h0);
        chk(rd, 32'h1, "power-on cause");
        bus(1'b1, `BIS_PARTNUM_ADDR, 32'hffff_ffff);
        bus(1'b0, `BIS_PARTNUM_ADDR, 32'h0);
        chk(rd, 32'h0000_1234, "part number");
        bus(1'b0, `BIS_REVID_ADDR, 32'h0);
        chk(rd, 32'h0000_0001, "revision");
        bus(1'b0, 32'h3018_0010, 32'h0);
        chk(rd, 32'h0, "unmapped");
      end
    join
    bus(1'b1, `BIS_CTRL_ADDR, 32'h0);
    chk(32'(loader_enable), 32'h0, "locked control");
    bus(1'b0, `BIS_BSTAT_ADDR, 32'h0);
    chk(rd, 32'h003f_ffff, "status word");
    bus(1'b0, `BIS_STAT_ADDR, 32'h0);
    chk(rd, 32'h0000_7e16, "status");
    xe <= 1'b0;
    pins <= 3'h5;
    pin_reset(1'b0);
    bus(1'b1, `BIS_CTRL_ADDR, 32'h0);
    chk(32'(loader_enable), 32'h1, "loader on");
    run_seq(1'b0, 1'b0);
    xe <= 1'b1;
    pins <= 3'h2;
    pin_reset(1'b1);
    run_seq(1'b1, 1'b1);
    print_verdict;
  end
endmodule // tb_boot_init_sequencer

`default_nettype wire
